// ===== psw_pkg.sv
// shared constants for the serial wiper interface
package psw_pkg;

  // word layout: two zero bits, four command bits, ten data bits
  localparam int WORD_W       = 16;
  localparam int DATA_W       = 10;
  localparam int CMD_W        = 4;
  localparam int CMD_MSB      = 13;
  localparam int CMD_LSB      = 10;
  localparam int CNT_W        = 4;
  localparam int PROTECT_POS  = 1;

  // reset values
  localparam logic [DATA_W-1:0] WIPER_MIDSCALE = 10'h200;
  localparam logic              PROTECT_RESET  = 1'h0;
  localparam logic [WORD_W-1:0] OUT_WORD_RESET = 16'h0000;

  // command codes
  localparam logic [CMD_W-1:0] CMD_NOP        = 4'h0;
  localparam logic [CMD_W-1:0] CMD_WIPER_WR   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_WIPER_RD   = 4'h2;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 4'h4;
  localparam logic [CMD_W-1:0] CMD_CTRL_WR    = 4'h6;

  // timing, longest times rounded down to whole mclk cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_WRITE_NS    = 410;
  localparam int T_READ_NS     = 450;
  localparam int T_RESET_NS    = 1500000;
  localparam int WRITE_CYCLES  = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int READ_CYCLES   = T_READ_NS / CLK_PERIOD_NS;
  localparam int RESET_CYCLES  = T_RESET_NS / CLK_PERIOD_NS;
  localparam int BUSY_W        = 17;

endpackage : psw_pkg

// ===== psw_link_shifter.sv
// serial-clock side: input shifter, bit counter and open-drain output
`timescale 1ns/1ns
module psw_link_shifter
  import psw_pkg::*;
(
  input  wire logic              sclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              frameSyncN,
  input  wire logic              serialIn,
  input  wire logic [WORD_W-1:0] loadWord,
  output logic      [WORD_W-1:0] shiftWord,
  output logic      [CNT_W-1:0]  bitCnt,
  output logic                   fullSeen,
  output logic                   serialOutOeN
);

  logic startPending_q;
  logic outBit_q;

  // armed while the frame line is high, so the first fall of a frame restarts
  // the count; sclk may stand still between frames
  always_ff @(negedge sclk or posedge rst or posedge frameSyncN)
  begin
    if (rst || frameSyncN)
      startPending_q <= 1'h1;
    else if (ce)
      startPending_q <= 1'h0;
  end

  // falling-edge shift, 16 bits, only in frame
  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
    begin
      shiftWord <= OUT_WORD_RESET;
      bitCnt    <= 4'h0;
      fullSeen  <= 1'h0;
    end
    else if (ce && !frameSyncN)
    begin
      if (startPending_q)
      begin
        shiftWord <= {loadWord[WORD_W-2:0], serialIn};
        bitCnt    <= 4'h1;
        fullSeen  <= 1'h0;
      end
      else
      begin
        shiftWord <= {shiftWord[WORD_W-2:0], serialIn};
        bitCnt    <= bitCnt + 4'h1;              // wraps every 16
        fullSeen  <= fullSeen | (bitCnt == 4'hF);
      end
    end
  end

  // output bit changes on the rising edge
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      outBit_q <= 1'h1;
    else if (ce)
      outBit_q <= startPending_q ? loadWord[WORD_W-1] : shiftWord[WORD_W-1];
  end

  // open drain: only pulls low inside a frame, pull-up gives high
  assign serialOutOeN = frameSyncN | outBit_q;

  // sampled bit lands in bit 0
  shift_in_a : assert property (@(negedge sclk) disable iff (rst)
    (!frameSyncN && ce && !startPending_q) |=> shiftWord[0] == $past(serialIn))
    else $error("serial bit not shifted in");

  // output follows the shifter one bit behind
  shift_out_a : assert property (@(posedge sclk) disable iff (rst)
    (ce && !startPending_q) |=> outBit_q == $past(shiftWord[WORD_W-1]))
    else $error("serial out does not follow shifter");

endmodule : psw_link_shifter

// ===== psw_wiper_ctrl.sv
// serial wiper interface: frame decode, wiper register, ready line
//
// What this block does
// - hardware reset loads wiper with midscale
// - reset acts on low-to-high edge only
// - input shift register is 16 bits
// - serial bit sampled on falling clock edge
// - frame line low enables shifting
// - frame close updates selected register after 16
// - short frame aborted, nothing changes
// - serial out is open drain
// - shift register contents appear on serial out
// - open-drain ready flag marks wiper operation done
// - word: two zeros, command, ten data
// - frame length counted in multiples of 16
// - output bit presented after rising clock edge
// - wiper writes blocked until protect bit set
`timescale 1ns/1ns
module psw_wiper_ctrl
  import psw_pkg::*;
#(
  parameter int RESET_CNT = RESET_CYCLES
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              frameSyncN,
  input  wire logic              serialIn,
  input  wire logic              serialOutIn,
  output logic                   serialOut,
  output logic                   serialOutOeN,
  input  wire logic              hwResetPin,
  input  wire logic              doneFlagIn,
  output logic                   doneFlag,
  output logic                   doneFlagOeN,
  output logic      [DATA_W-1:0] wiperPosition,
  output logic                   writeProtect
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } psw_state_t;

  psw_state_t        state_q;
  psw_state_t        state_d;
  logic [WORD_W-1:0] linkWord;
  logic [CNT_W-1:0]  linkCnt;
  logic              linkFull;
  logic [WORD_W-1:0] outWord_q;
  logic              fsMeta_q;
  logic              fsSync_q;
  logic              fsPrev_q;
  logic              hrMeta_q;
  logic              hrSync_q;
  logic              hrPrev_q;
  logic [BUSY_W-1:0] busyCnt_q;
  logic [BUSY_W-1:0] busyLoad;
  logic [DATA_W-1:0] wiper_q;
  logic              protect_q;

  // link-side shifter on the serial clock
  psw_link_shifter u_link (
    .sclk         (sclk),
    .rst          (rst),
    .ce           (ce),
    .frameSyncN   (frameSyncN),
    .serialIn     (serialIn),
    .loadWord     (outWord_q),
    .shiftWord    (linkWord),
    .bitCnt       (linkCnt),
    .fullSeen     (linkFull),
    .serialOutOeN (serialOutOeN)
  );

  // two-flop synchronisers for the frame line and the reset pin; idle high
  // so a tied-high reset pin never fires after power-up
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fsMeta_q <= 1'h1;
      fsSync_q <= 1'h1;
      fsPrev_q <= 1'h1;
      hrMeta_q <= 1'h1;
      hrSync_q <= 1'h1;
      hrPrev_q <= 1'h1;
    end
    else if (ce)
    begin
      fsMeta_q <= frameSyncN;
      fsSync_q <= fsMeta_q;
      fsPrev_q <= fsSync_q;
      hrMeta_q <= hwResetPin;
      hrSync_q <= hrMeta_q;
      hrPrev_q <= hrSync_q;
    end
  end

  // frame close; link word and count are frozen while the line is high,
  // so two flops of latency before reading them is safe
  wire closeEvt = ce & fsSync_q & ~fsPrev_q;
  // only the rising edge of the reset pin acts
  wire hwRise   = ce & hrSync_q & ~hrPrev_q;

  // count must land on a multiple of 16, and reach 16 at all
  wire frameOk  = linkFull & (linkCnt == 4'h0);
  wire [CMD_W-1:0]  cmd  = linkWord[CMD_MSB:CMD_LSB];
  wire [DATA_W-1:0] data = linkWord[DATA_W-1:0];

  wire takeWord = closeEvt & frameOk & ~hwRise;
  wire isWrite  = takeWord & (cmd == CMD_WIPER_WR);
  wire isRead   = takeWord & (cmd == CMD_WIPER_RD);
  wire isSoft   = takeWord & (cmd == CMD_SOFT_RESET);
  wire isCtrl   = takeWord & (cmd == CMD_CTRL_WR);
  wire startOp  = hwRise | isWrite | isRead | isSoft;

  // busy length per operation; a reset outranks any frame closing with it
  assign busyLoad = hwRise | isSoft ? BUSY_W'(RESET_CNT)
                  : isRead          ? BUSY_W'(READ_CYCLES)
                  :                   BUSY_W'(WRITE_CYCLES);

  // midscale on reset, update at close, protect gate
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wiper_q   <= WIPER_MIDSCALE;
      protect_q <= PROTECT_RESET;
    end
    else if (hwRise || isSoft)
      wiper_q   <= WIPER_MIDSCALE;
    else if (isWrite && protect_q)
      wiper_q   <= data;
    else if (isCtrl)
      protect_q <= data[PROTECT_POS];
  end

  // next frame returns the last word (daisy chain) or the wiper
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      outWord_q <= OUT_WORD_RESET;
    else if (isRead)
      outWord_q <= {{(WORD_W-DATA_W){1'h0}}, wiper_q};
    else if (takeWord)
      outWord_q <= linkWord;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (startOp) state_d = ST_BUSY;
      ST_BUSY: if (busyCnt_q == BUSY_W'(1) && !startOp) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // busy counter, restarted by any new operation
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= ST_IDLE;
      busyCnt_q <= '0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if (startOp)
        busyCnt_q <= busyLoad;
      else if (busyCnt_q != '0)
        busyCnt_q <= busyCnt_q - BUSY_W'(1);
    end
  end

  // open-drain ready: pulled low while busy, released when done
  assign doneFlagOeN   = (state_q != ST_BUSY);
  assign doneFlag      = 1'h0;
  assign serialOut     = 1'h0;
  assign wiperPosition = wiper_q;
  assign writeProtect  = protect_q;

  localparam int WR_CYC  = WRITE_CYCLES;
  localparam int RD_CYC  = READ_CYCLES;
  localparam int WR_CYC1 = WRITE_CYCLES + 1;
  localparam int RD_CYC1 = READ_CYCLES + 1;

  logic [BUSY_W-1:0] lowRun_q;
  logic              lastWr_q;

  // checker helper: length of the current ready-low run, restarted by any new
  // operation; a counter keeps the property small for long busy times
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lowRun_q <= '0;
      lastWr_q <= 1'h0;
    end
    else if (ce)
    begin
      if (startOp)
        lowRun_q <= '0;
      else if (!doneFlagOeN)
        lowRun_q <= lowRun_q + BUSY_W'(1);
      if (startOp)
        lastWr_q <= isWrite;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst || !ce);

  hw_reset_mid_a : assert property (hwRise |=> wiper_q == WIPER_MIDSCALE)
    else $error("hardware reset did not load midscale");
  reset_level_a : assert property (hrSync_q && hrPrev_q && !takeWord |=> $stable(wiper_q))
    else $error("reset level changed the wiper");
  frame_write_a : assert property (isWrite && protect_q |=> wiper_q == $past(data))
    else $error("wiper not loaded at frame close");
  abort_keep_a : assert property (closeEvt && !frameOk && !hwRise
    |=> $stable(wiper_q) && $stable(protect_q) && $stable(outWord_q))
    else $error("short frame changed state");
  protect_block_a : assert property (isWrite && !protect_q |=> $stable(wiper_q))
    else $error("write went through while protected");
  readback_load_a : assert property (isRead |=> outWord_q[DATA_W-1:0] == $past(wiper_q))
    else $error("readback word not loaded");
  ctrl_write_a : assert property (isCtrl |=> protect_q == $past(data[PROTECT_POS]))
    else $error("protect bit not loaded");
  write_ready_a : assert property ($rose(doneFlagOeN) && lastWr_q
    |-> lowRun_q == BUSY_W'(WR_CYC))
    else $error("ready low time wrong after write");
  read_ready_a : assert property (isRead |=> !doneFlagOeN ##[RD_CYC:RD_CYC1]
    (doneFlagOeN || $past(startOp)))
    else $error("ready not released after read");
  write_rel_a : assert property (isWrite |=> ##[WR_CYC:WR_CYC1]
    (doneFlagOeN || $past(startOp) || !doneFlagOeN && busyCnt_q > BUSY_W'(WR_CYC)))
    else $error("ready not released after write");

  write_seen_c : cover property (isWrite && protect_q);
  read_seen_c  : cover property (isRead);
  abort_seen_c : cover property (closeEvt && !frameOk);
  hw_reset_c   : cover property (hwRise);

endmodule : psw_wiper_ctrl

// ===== psw_host_model.sv
// host-side model: frames driven onto the serial link
`timescale 1ns/1ns
module psw_host_model
(
  input  wire logic mclk,
  input  wire logic soWire,
  output logic      sclk,
  output logic      frameSyncN,
  output logic      serialIn
);
  // serial clock stands still low between frames
  initial
  begin
    sclk       = 1'h0;
    frameSyncN = 1'h1;
    serialIn   = 1'h0;
  end

  // one frame of nBits, readback collected on falling edges
  task automatic frame(input logic [31:0] word, input int nBits, output logic [31:0] rd);
    rd = 32'h0;
    @(negedge mclk);
    frameSyncN = 1'h0;
    #37;
    for (int i = nBits - 1; i >= 0; i--)
    begin
      sclk     = 1'h1;
      serialIn = word[i];
      #80;
      sclk = 1'h0;
      rd   = {rd[30:0], soWire};
      #80;
    end
    frameSyncN = 1'h1;
    // released line shows the inverse, never a stale bit
    serialIn = ~serialIn;
  endtask : frame
endmodule : psw_host_model

// ===== psw_wiper_ctrl_tb.sv
// self-checking bench for the serial wiper interface
`timescale 1ns/1ns
module psw_wiper_ctrl_tb
  import psw_pkg::*;
;
  localparam int RST_CNT = 50;
  logic              mclk       = 1'h0;
  logic              rst        = 1'h1;
  logic              hwResetPin = 1'h0;
  logic              sclk, frameSyncN, serialIn, serialOut, serialOutOeN;
  logic              doneFlag, doneFlagOeN, writeProtect, soWire, rdyWire;
  logic [DATA_W-1:0] wiperPosition;
  logic [31:0]       rd;
  int                bad_count = 0;
  int                tests_run = 0;

  // 50 MHz core clock
  always #10 mclk = ~mclk;

  // pull-ups on both open-drain lines
  assign soWire  = serialOutOeN ? 1'h1 : serialOut;
  assign rdyWire = doneFlagOeN ? 1'h1 : doneFlag;

  psw_wiper_ctrl #(.RESET_CNT(RST_CNT)) u_dut (
    .mclk(mclk), .rst(rst), .ce(1'h1), .sclk(sclk), .frameSyncN(frameSyncN),
    .serialIn(serialIn), .serialOutIn(soWire), .serialOut(serialOut),
    .serialOutOeN(serialOutOeN), .hwResetPin(hwResetPin), .doneFlagIn(rdyWire),
    .doneFlag(doneFlag), .doneFlagOeN(doneFlagOeN), .wiperPosition(wiperPosition),
    .writeProtect(writeProtect));

  psw_host_model u_host (
    .mclk(mclk), .soWire(soWire), .sclk(sclk), .frameSyncN(frameSyncN),
    .serialIn(serialIn));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ready low length in mclk cycles, 0 when no pulse is due
  task automatic busy_len(input int expLow);
    int w;
    int n;
    for (w = 0; w < 10 && rdyWire !== 1'h0; w++)
      @(negedge mclk);
    for (n = 0; n < 200 && rdyWire === 1'h0; n++)
      @(negedge mclk);
    check("ready low cycles", 16'(n), 16'(expLow));
    if (n == 200)
      complete_run();
    // keeps the 500 ns frame-high spacing
    repeat (25)
      @(negedge mclk);
  endtask : busy_len

  task automatic op(input logic [31:0] word, input int nBits, input int expLow);
    u_host.frame(word, nBits, rd);
    busy_len(expLow);
  endtask : op

  task automatic sc_reset();
    check("wiper", 16'(wiperPosition), 16'(WIPER_MIDSCALE));
    check("protect", 16'(writeProtect), 16'(PROTECT_RESET));
    check("ready", 16'(rdyWire), 16'h0001);
  endtask : sc_reset

  task automatic sc_protected();
    op(32'h0500, 16, WRITE_CYCLES);
    check("wiper", 16'(wiperPosition), 16'h0200);
  endtask : sc_protected

  task automatic sc_enable();
    op(32'h1802, 16, 0);
    check("protect", 16'(writeProtect), 16'h0001);
    check("daisy out", rd[15:0], 16'h0500);
  endtask : sc_enable

  task automatic sc_write();
    op(32'h0500, 16, WRITE_CYCLES);
    check("wiper", 16'(wiperPosition), 16'h0100);
    check("daisy out", rd[15:0], 16'h1802);
  endtask : sc_write

  task automatic sc_abort();
    op(32'h05FF, 15, 0);
    check("wiper", 16'(wiperPosition), 16'h0100);
  endtask : sc_abort

  task automatic sc_long();
    op(32'h05AA0533, 32, WRITE_CYCLES);
    check("wiper", 16'(wiperPosition), 16'h0133);
  endtask : sc_long

  task automatic sc_read();
    op(32'h0800, 16, READ_CYCLES);
    op(32'h0000, 16, 0);
    check("readback", rd[15:0], 16'h0133);
  endtask : sc_read

  task automatic sc_soft();
    op(32'h1000, 16, RST_CNT);
    check("wiper", 16'(wiperPosition), 16'(WIPER_MIDSCALE));
  endtask : sc_soft

  // pin acts on its rising edge only, not on level or fall
  task automatic sc_hw();
    op(32'h0555, 16, WRITE_CYCLES);
    hwResetPin = 1'h1;
    busy_len(RST_CNT);
    check("wiper", 16'(wiperPosition), 16'(WIPER_MIDSCALE));
    op(32'h0555, 16, WRITE_CYCLES);
    hwResetPin = 1'h0;
    repeat (10)
      @(negedge mclk);
    check("wiper", 16'(wiperPosition), 16'h0155);
  endtask : sc_hw

  // main sequence: reset held four cycles, then each scenario
  initial
  begin
    repeat (4)
      @(negedge mclk);
    rst = 1'h0;
    repeat (4)
      @(negedge mclk);
    sc_reset();
    sc_protected();
    sc_enable();
    sc_write();
    sc_abort();
    sc_long();
    sc_read();
    sc_soft();
    sc_hw();
    complete_run();
  end
endmodule : psw_wiper_ctrl_tb
